// File: fms_sequencer.sv
// Flash command sequencer: field margin, section erase-verify and data flash program
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps

// Notes on behaviour
// - Code 0x0E sets field margin, special modes only; index 0 block, index 1 level.
// - Margin command stores the level for later reads of the block, then completes.
// - Levels 0..4 are normal, user 1/0, field 1/0; anything else is invalid.
// - Level 1 settings shift reads toward erased, level 0 toward programmed.
// - Margin access error on index not 1, wrong mode, bad block or level.
// - Code 0x10 erase-verifies a data flash section: block, first word, count.
// - Every word of the section is checked erased; complete flag set at the end.
// - Erase-verify access error: index not 2, bad address, odd, zero count, past end.
// - Erase-verify read errors set verify flags; never a protection violation.
// - Code 0x11 programs one to four words; indices 2 to 5 carry data.
// - Word count comes from the launch index; program only unprotected areas.
// - Program access error: index outside 2..5, address, odd, past end.
// - Any protected target word raises protection violation and nothing is written.
// - Programmed words are read back; errors set the verify flags.
module fms_sequencer #(
  parameter int         DEPTH  = fms_pkg::FMS_DEPTH,
  parameter logic [6:0] DF_BLK = 7'h10,
  parameter logic [6:0] PF_BLK = 7'h7f
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire fms_pkg::fms_reg_req_s bus,
  output logic      [15:0]          reg_rdata,
  input  wire logic                 special_mode,
  output logic                      irq,
  output fms_pkg::fms_margin_s      margin
);
  import fms_pkg::*;

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || DEPTH > 32768) begin : g_bad_depth
    $error("DEPTH must lie between 4 and 32768 words");
  end

  typedef struct packed {
    fms_state_e       st;
    logic [1:0]       msync;
    logic             command_complete_flag;
    logic             access_error_flag;
    logic             protection_violation_flag;
    logic             mg1;
    logic             mg0;
    logic [2:0]       idx;
    logic [2:0]       lidx;
    logic [5:0][15:0] param;
    logic [15:0]      prot;
    logic [15:0]      ptr;
    logic [15:0]      cnt;
    logic [1:0]       wn;
    logic             pend;
    logic [15:0]      exp;
    logic [1:0]       istat;
    logic [1:0]       imask;
    logic [2:0]       dmarg;
    logic [2:0]       pmarg;
    logic [15:0]      rdata;
  } fms_regs_s;

  fms_regs_s q;
  fms_regs_s next_q;
  fms_chk_s  chk;

  logic                     mem_we;
  logic [AW-1:0]            mem_waddr;
  logic [FMS_MEM_WIDTH-1:0] mem_wdata;
  logic                     mem_re;
  logic [AW-1:0]            mem_raddr;
  logic [FMS_MEM_WIDTH-1:0] mem_rdata;

  fms_word_mem #(
    .WIDTH (FMS_MEM_WIDTH),
    .DEPTH (DEPTH)
  ) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .re    (mem_re),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  fms_cmd_check #(
    .DEPTH  (DEPTH),
    .DF_BLK (DF_BLK),
    .PF_BLK (PF_BLK)
  ) u_check (
    .param        (q.param),
    .launch_idx   (q.lidx),
    .special_mode (q.msync[1]),
    .prot         (q.prot),
    .chk          (chk)
  );

  logic [15:0] stat_word;
  logic        done_ev;
  logic        err_ev;
  logic [15:0] waddr16;

  always_comb begin
    next_q    = q;
    done_ev   = 1'b0;
    err_ev    = 1'b0;
    mem_we    = 1'b0;
    mem_re    = 1'b0;
    mem_waddr = '0;
    mem_raddr = '0;
    mem_wdata = '0;
    waddr16   = 16'(q.ptr + 16'(q.wn));
    stat_word = '0;
    stat_word[FMS_COMMAND_COMPLETE_FLAG_BIT]   = q.command_complete_flag;
    stat_word[FMS_ACCESS_ERROR_FLAG_BIT] = q.access_error_flag;
    stat_word[FMS_PROTECTION_VIOLATION_FLAG_BIT] = q.protection_violation_flag;
    stat_word[FMS_MG1_BIT]    = q.mg1;
    stat_word[FMS_MG0_BIT]    = q.mg0;
    // Mode pin arrives from outside the clock domain
    next_q.msync = {q.msync[0], special_mode};

    next_q.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        FMS_REG_STAT:   next_q.rdata = stat_word;
        FMS_REG_INDEX:  next_q.rdata = {13'h0, q.idx};
        FMS_REG_PARAM:  next_q.rdata = (q.idx <= FMS_IX_LAST) ? q.param[q.idx] : 16'h0000;
        FMS_REG_PROT:   next_q.rdata = q.prot;
        FMS_REG_ISTAT:  next_q.rdata = {14'h0, q.istat};
        FMS_REG_IMASK:  next_q.rdata = {14'h0, q.imask};
        FMS_REG_MARGIN: next_q.rdata = {5'h0, q.pmarg, 5'h0, q.dmarg};
        default:        next_q.rdata = '0;
      endcase
    end

    // Parameter and protection writes are dropped while busy
    if (bus.wr) begin
      case (bus.addr)
        FMS_REG_STAT: begin
          if (bus.wdata[FMS_ACCESS_ERROR_FLAG_BIT]) next_q.access_error_flag = 1'b0;
          if (bus.wdata[FMS_PROTECTION_VIOLATION_FLAG_BIT]) next_q.protection_violation_flag = 1'b0;
          // A launch is refused while an earlier access error or protection violation is still standing
          if (q.command_complete_flag && bus.wdata[FMS_COMMAND_COMPLETE_FLAG_BIT] && !next_q.access_error_flag && !next_q.protection_violation_flag) begin
            next_q.command_complete_flag = 1'b0;
            next_q.mg1  = 1'b0;
            next_q.mg0  = 1'b0;
            next_q.lidx = q.idx;
            next_q.st   = S_CHECK;
          end
        end
        FMS_REG_INDEX: if (q.command_complete_flag) next_q.idx = bus.wdata[2:0];
        FMS_REG_PARAM: if (q.command_complete_flag && q.idx <= FMS_IX_LAST) next_q.param[q.idx] = bus.wdata;
        FMS_REG_PROT:  if (q.command_complete_flag) next_q.prot = bus.wdata;
        FMS_REG_ISTAT: next_q.istat = q.istat & ~bus.wdata[1:0];
        FMS_REG_IMASK: next_q.imask = bus.wdata[1:0];
        default: ;
      endcase
    end

    // Compare the read issued in the previous cycle
    next_q.pend = 1'b0;
    if (q.pend) begin
      if (mem_rdata[15:0] != q.exp) begin
        next_q.mg1 = 1'b1;
        err_ev     = 1'b1;
      end
      if (mem_rdata[16] != fms_check_bit(mem_rdata[15:0])) begin
        next_q.mg1 = 1'b1;
        next_q.mg0 = 1'b1;
        err_ev     = 1'b1;
      end
    end

    case (q.st)
      S_INIT: begin
        // Sweep leaves the whole array erased; no command is taken meanwhile
        mem_we    = 1'b1;
        mem_waddr = AW'(q.ptr);
        mem_wdata = {fms_check_bit(FMS_ERASED), FMS_ERASED};
        next_q.ptr = 16'(q.ptr + 16'h1);
        if (q.ptr == 16'(DEPTH - 1)) begin
          next_q.command_complete_flag = 1'b1;
          next_q.st   = S_IDLE;
        end
      end
      S_IDLE: ;
      S_CHECK: begin
        if (chk.acc_err) begin
          next_q.access_error_flag = 1'b1;
          err_ev        = 1'b1;
          next_q.st     = S_DONE;
        end else if (chk.prot_viol) begin
          next_q.protection_violation_flag = 1'b1;
          err_ev        = 1'b1;
          next_q.st     = S_DONE;
        end else begin
          next_q.ptr = chk.start;
          next_q.cnt = chk.count;
          next_q.wn  = '0;
          case (chk.kind)
            CMD_MARGIN: next_q.st = S_MARGIN;
            CMD_EVSECT: next_q.st = S_EV;
            CMD_PROG:   next_q.st = S_PW;
            default:    next_q.st = S_DONE;
          endcase
        end
      end
      S_MARGIN: begin
        if (q.param[FMS_IX_CODE][6:0] == DF_BLK) begin
          next_q.dmarg = q.param[FMS_IX_ADDR][2:0];
        end else begin
          next_q.pmarg = q.param[FMS_IX_ADDR][2:0];
        end
        next_q.st = S_DONE;
      end
      S_EV: begin
        mem_re      = 1'b1;
        mem_raddr   = AW'(q.ptr);
        next_q.pend = 1'b1;
        next_q.exp  = FMS_ERASED;
        next_q.ptr  = 16'(q.ptr + 16'h1);
        next_q.cnt  = 16'(q.cnt - 16'h1);
        if (q.cnt == 16'h1) next_q.st = S_DRAIN;
      end
      S_PW: begin
        mem_we    = 1'b1;
        mem_waddr = AW'(waddr16);
        mem_wdata = {fms_check_bit(q.param[3'(FMS_IX_DATA0 + 3'(q.wn))]),
                     q.param[3'(FMS_IX_DATA0 + 3'(q.wn))]};
        next_q.wn = 2'(q.wn + 2'h1);
        if (16'(q.wn) == 16'(q.cnt - 16'h1)) begin
          next_q.wn = '0;
          next_q.st = S_PV;
        end
      end
      S_PV: begin
        mem_re      = 1'b1;
        mem_raddr   = AW'(waddr16);
        next_q.pend = 1'b1;
        next_q.exp  = q.param[3'(FMS_IX_DATA0 + 3'(q.wn))];
        next_q.wn   = 2'(q.wn + 2'h1);
        if (16'(q.wn) == 16'(q.cnt - 16'h1)) next_q.st = S_DRAIN;
      end
      S_DRAIN: next_q.st = S_DONE;
      S_DONE: begin
        next_q.command_complete_flag = 1'b1;
        done_ev     = 1'b1;
        next_q.st   = S_IDLE;
      end
      default: next_q.st = S_IDLE;
    endcase

    // Events are applied last so that a set wins over a clear
    if (done_ev) next_q.istat[FMS_IRQ_DONE] = 1'b1;
    if (err_ev)  next_q.istat[FMS_IRQ_ERR]  = 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.st    <= S_INIT;
      q.prot  <= FMS_PROT_RST;
      q.imask <= FMS_IMASK_RST;
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq       = |(q.istat & q.imask);

  always_comb begin
    margin.dflash_level = q.dmarg;
    margin.pflash_level = q.pmarg;
    margin.dflash_shift = fms_shift(q.dmarg);
    margin.pflash_shift = fms_shift(q.pmarg);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_abort_prompt: assert property (
    (q.st == S_CHECK && chk.acc_err) |=> q.access_error_flag && !mem_we ##1 q.command_complete_flag)
    else $error("access error did not abort and complete");
  a_prot_no_write: assert property (
    (q.st == S_CHECK && !chk.acc_err && chk.prot_viol) |=> (q.protection_violation_flag && !mem_we) ##1 q.command_complete_flag)
    else $error("protection violation did not block programming");
  a_margin_applied: assert property (
    (q.st == S_CHECK && !chk.acc_err && chk.kind == CMD_MARGIN) |=> ##2
      (q.command_complete_flag && (q.dmarg == q.param[FMS_IX_ADDR][2:0] || q.pmarg == q.param[FMS_IX_ADDR][2:0])))
    else $error("margin level not stored before completion");
  a_margin_mode: assert property (
    (q.st == S_CHECK && chk.kind == CMD_MARGIN && !q.msync[1]) |=> q.access_error_flag)
    else $error("margin command accepted outside special mode");
  a_margin_level: assert property (
    (q.st == S_CHECK && chk.kind == CMD_MARGIN && q.param[FMS_IX_ADDR] > FMS_MG_FIELD0)
      |=> q.access_error_flag)
    else $error("invalid margin level accepted");
  a_margin_flags: assert property (
    (q.st == S_MARGIN) |=> (!q.protection_violation_flag && !q.mg1 && !q.mg0))
    else $error("margin command raised protection or verify flag");
  a_shift_dir: assert property (
    (q.dmarg == 3'h3 || q.dmarg == 3'h1) |-> margin.dflash_shift == FMS_SHIFT_ERSD)
    else $error("level 1 margin not shifted toward erased");
  a_ev_no_protection_violation_flag: assert property (
    (q.st == S_EV) |=> !q.protection_violation_flag)
    else $error("erase-verify raised protection violation");
  a_ev_finish: assert property (
    (q.st == S_EV && q.cnt == 16'h1) |=> q.st == S_DRAIN ##1 q.st == S_DONE ##1 q.command_complete_flag)
    else $error("erase-verify did not complete after last word");
  a_prog_count: assert property (
    (q.st == S_CHECK && !chk.acc_err && !chk.prot_viol && chk.kind == CMD_PROG)
      |=> (q.st == S_PW && q.cnt == 16'(q.lidx) - 16'h1))
    else $error("program word count not taken from launch index");
  a_verify_flag: assert property (
    (q.pend && mem_rdata[16] != fms_check_bit(mem_rdata[15:0])) |=> (q.mg0 && q.mg1))
    else $error("uncorrectable read did not set both verify flags");

  c_margin_done: cover property ((q.st == S_MARGIN) ##2 q.command_complete_flag);
  c_ev_error:    cover property ((q.st == S_DRAIN) ##1 q.mg1);
  c_prog_four:   cover property ((q.st == S_PW && q.cnt == 16'h4) ##[1:12] q.st == S_DONE);
  c_prot_viol:   cover property ($rose(q.protection_violation_flag));

endmodule

// File: fms_pkg.sv
// Shared constants and types of the flash margin, erase-verify and program sequencer
package fms_pkg;

  localparam int unsigned FMS_DEPTH     = 2048;
  localparam int unsigned FMS_MEM_WIDTH = 17;

  // Register offsets (word addresses of the plain register port)
  localparam logic [3:0] FMS_REG_STAT   = 4'h0;
  localparam logic [3:0] FMS_REG_INDEX  = 4'h1;
  localparam logic [3:0] FMS_REG_PARAM  = 4'h2;
  localparam logic [3:0] FMS_REG_PROT   = 4'h3;
  localparam logic [3:0] FMS_REG_ISTAT  = 4'h4;
  localparam logic [3:0] FMS_REG_IMASK  = 4'h5;
  localparam logic [3:0] FMS_REG_MARGIN = 4'h6;

  // Bit positions in the flash status register
  localparam int unsigned FMS_COMMAND_COMPLETE_FLAG_BIT   = 7;
  localparam int unsigned FMS_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int unsigned FMS_PROTECTION_VIOLATION_FLAG_BIT = 4;
  localparam int unsigned FMS_MG1_BIT    = 1;
  localparam int unsigned FMS_MG0_BIT    = 0;

  // Interrupt status and mask bits
  localparam int unsigned FMS_IRQ_DONE = 0;
  localparam int unsigned FMS_IRQ_ERR  = 1;

  // Protection register: enable bit and boundary field
  localparam int unsigned FMS_PROT_EN_BIT = 15;

  // Command codes
  localparam logic [7:0] FMS_CMD_MARGIN = 8'h0e;
  localparam logic [7:0] FMS_CMD_EVSECT = 8'h10;
  localparam logic [7:0] FMS_CMD_PROG   = 8'h11;

  // Parameter word indices
  localparam logic [2:0] FMS_IX_CODE  = 3'h0;
  localparam logic [2:0] FMS_IX_ADDR  = 3'h1;
  localparam logic [2:0] FMS_IX_DATA0 = 3'h2;
  localparam logic [2:0] FMS_IX_LAST  = 3'h5;

  // Margin settings
  localparam logic [15:0] FMS_MG_NORMAL = 16'h0000;
  localparam logic [15:0] FMS_MG_USER1  = 16'h0001;
  localparam logic [15:0] FMS_MG_USER0  = 16'h0002;
  localparam logic [15:0] FMS_MG_FIELD1 = 16'h0003;
  localparam logic [15:0] FMS_MG_FIELD0 = 16'h0004;

  // Read-margin shift codes
  localparam logic [1:0] FMS_SHIFT_NONE = 2'h0;
  localparam logic [1:0] FMS_SHIFT_ERSD = 2'h1;
  localparam logic [1:0] FMS_SHIFT_PGMD = 2'h2;

  // Values after reset
  localparam logic [15:0] FMS_PROT_RST  = 16'h0000;
  localparam logic [1:0]  FMS_IMASK_RST = 2'h0;
  localparam logic [15:0] FMS_ERASED    = 16'hffff;

  typedef enum logic [1:0] {CMD_NONE, CMD_MARGIN, CMD_EVSECT, CMD_PROG} fms_cmd_e;

  typedef enum logic [3:0] {
    S_INIT, S_IDLE, S_CHECK, S_MARGIN, S_EV, S_PW, S_PV, S_DRAIN, S_DONE
  } fms_state_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } fms_reg_req_s;

  typedef struct packed {
    logic [2:0] dflash_level;
    logic [2:0] pflash_level;
    logic [1:0] dflash_shift;
    logic [1:0] pflash_shift;
  } fms_margin_s;

  typedef struct packed {
    fms_cmd_e    kind;
    logic        acc_err;
    logic        prot_viol;
    logic [15:0] start;
    logic [15:0] count;
  } fms_chk_s;

  // Check bit stored beside each word; a clash marks a word as uncorrectable
  function automatic logic fms_check_bit(input logic [15:0] d);
    return ^d;
  endfunction

  function automatic logic [1:0] fms_shift(input logic [2:0] lvl);
    case (lvl)
      3'h1, 3'h3: return FMS_SHIFT_ERSD;
      3'h2, 3'h4: return FMS_SHIFT_PGMD;
      default:    return FMS_SHIFT_NONE;
    endcase
  endfunction

endpackage

// File: fms_word_mem.sv
// Data flash word array with registered read data
`timescale 1ns/10ps
module fms_word_mem #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2048,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  if (DEPTH < 2) begin : g_bad_depth
    $error("word memory needs at least two words");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// File: fms_cmd_check.sv
// Launch-time parameter check of the loaded command
`timescale 1ns/10ps
module fms_cmd_check #(
  parameter int         DEPTH  = 2048,
  parameter logic [6:0] DF_BLK = 7'h10,
  parameter logic [6:0] PF_BLK = 7'h7f
) (
  input  wire logic [5:0][15:0] param,
  input  wire logic [2:0]       launch_idx,
  input  wire logic             special_mode,
  input  wire logic [15:0]      prot,
  output fms_pkg::fms_chk_s     chk
);
  import fms_pkg::*;

  localparam logic [16:0] DEPTH17 = 17'(DEPTH);

  logic [6:0]  blk;
  logic        df_ok;
  logic        misaligned;
  logic [16:0] end17;

  always_comb begin
    blk        = param[FMS_IX_CODE][6:0];
    misaligned = param[FMS_IX_ADDR][0];
    df_ok      = (blk == DF_BLK) && ({2'h0, param[FMS_IX_ADDR][15:1]} < DEPTH17);
    chk           = '0;
    chk.start     = {1'b0, param[FMS_IX_ADDR][15:1]};
    chk.kind      = CMD_NONE;
    chk.acc_err   = 1'b1;
    end17         = '0;
    case (param[FMS_IX_CODE][15:8])
      FMS_CMD_MARGIN: begin
        chk.kind    = CMD_MARGIN;
        chk.acc_err = (launch_idx != FMS_IX_ADDR) || !special_mode
                    || !(blk == DF_BLK || blk == PF_BLK)
                    || (param[FMS_IX_ADDR] > FMS_MG_FIELD0);
      end
      FMS_CMD_EVSECT: begin
        chk.kind    = CMD_EVSECT;
        chk.count   = param[FMS_IX_DATA0];
        end17       = {1'b0, chk.start} + {1'b0, chk.count};
        // Empty sections are refused as well
        chk.acc_err = (launch_idx != FMS_IX_DATA0) || !df_ok || misaligned
                    || (chk.count == 16'h0000) || (end17 > DEPTH17);
      end
      FMS_CMD_PROG: begin
        chk.kind    = CMD_PROG;
        chk.count   = 16'(launch_idx) - 16'(FMS_IX_ADDR);
        end17       = {1'b0, chk.start} + {1'b0, chk.count};
        chk.acc_err = (launch_idx < FMS_IX_DATA0) || (launch_idx > FMS_IX_LAST)
                    || !df_ok || misaligned || (end17 > DEPTH17);
        chk.prot_viol = !chk.acc_err && prot[FMS_PROT_EN_BIT]
                      && ((end17 - 17'h1) >= {2'h0, prot[14:0]});
      end
      default: begin
        chk.kind    = CMD_NONE;
      end
    endcase
  end

endmodule

// File: fms_sequencer_tb.sv
// Self-checking bench of the flash command sequencer
`timescale 1ns/10ps
module fms_sequencer_tb;
  import fms_pkg::*;
  localparam int         DP = 16;
  localparam logic [6:0] DB = 7'h10;
  localparam logic [6:0] PB = 7'h7f;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         special_mode = 1'b0;
  fms_reg_req_s bus = '0;
  logic [15:0]  reg_rdata;
  logic         irq;
  fms_margin_s  margin;
  int           err_count = 0;
  int           checks = 0;
  int           cyc = 0;
  int           mem [DP];
  int           dl = 0;
  int           pl = 0;
  logic [15:0]  lfsr = 16'h3950;
  logic [15:0]  p [6];
  logic [15:0]  rv;
  logic [15:0]  prot = 16'h0000;

  fms_sequencer #(.DEPTH(DP), .DF_BLK(DB), .PF_BLK(PB)) u_fms_sequencer (
    .clk(clk), .rst(rst), .bus(bus), .reg_rdata(reg_rdata),
    .special_mode(special_mode), .irq(irq), .margin(margin));

  always #12.5 clk = ~clk;

  // Whole run needs roughly a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [1:0] sh(input int l);
    if (l == 1 || l == 3) return FMS_SHIFT_ERSD;
    if (l == 2 || l == 4) return FMS_SHIFT_PGMD;
    return FMS_SHIFT_NONE;
  endfunction

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_done();
    for (int k = 0; k < 200; k++) begin
      rd(FMS_REG_STAT, rv);
      if (rv[FMS_COMMAND_COMPLETE_FLAG_BIT] === 1'b1) break;
    end
  endtask

  // Clears leftover error flags in the same write that launches
  // No register write until the complete flag is back
  task automatic launch(input int n, input logic [2:0] ix);
    for (int i = 0; i < n; i++) begin
      wr(FMS_REG_INDEX, 16'(i));
      wr(FMS_REG_PARAM, p[i]);
    end
    wr(FMS_REG_INDEX, {13'h0, ix});
    wr(FMS_REG_STAT, 16'h00b0);
    wait_done();
  endtask

  task automatic stat(input int acc, input int pv, input int m1);
    rd(FMS_REG_STAT, rv);
    chk_reg(rv, 16'((1 << FMS_COMMAND_COMPLETE_FLAG_BIT) | (acc << FMS_ACCESS_ERROR_FLAG_BIT) |
                    (pv << FMS_PROTECTION_VIOLATION_FLAG_BIT) | (m1 << FMS_MG1_BIT)));
  endtask

  task automatic set_margin(input logic [6:0] blk, input int s, input logic [2:0] ix);
    int acc;
    p[0] = {FMS_CMD_MARGIN, 1'b0, blk};
    p[1] = 16'(s);
    acc = int'(ix != 3'h1 || !special_mode || (blk != DB && blk != PB) || s > 4);
    launch(2, ix);
    stat(acc, 0, 0);
    if (acc == 0 && blk == DB) dl = s;
    if (acc == 0 && blk == PB) pl = s;
    chk_pin(margin, {3'(dl), 3'(pl), sh(dl), sh(pl)});
    rd(FMS_REG_MARGIN, rv);
    chk_reg(rv, {5'h0, 3'(pl), 5'h0, 3'(dl)});
  endtask

  // Bench only targets erased words, never adding bits cumulatively
  task automatic prog(input int a, input logic [2:0] ix);
    int w;
    int n;
    int acc;
    int pv;
    w = a >> 1;
    n = int'(ix) - 1;
    p[0] = {FMS_CMD_PROG, 1'b0, DB};
    p[1] = 16'(a);
    for (int i = 2; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      p[i] = lfsr;
    end
    acc = int'(ix < 3'h2 || ix > 3'h5 || a % 2 != 0 || w + n > DP);
    pv = int'(acc == 0 && prot[FMS_PROT_EN_BIT] && w + n - 1 >= int'(prot[14:0]));
    if (acc == 0 && pv == 0) begin
      for (int i = 0; i < n; i++) mem[w + i] = int'(p[2 + i]);
    end
    launch(6, ix);
    stat(acc, pv, 0);
  endtask

  task automatic ev(input int a, input int cnt, input logic [2:0] ix);
    int w;
    int acc;
    int m1;
    w = a >> 1;
    m1 = 0;
    p[0] = {FMS_CMD_EVSECT, 1'b0, DB};
    p[1] = 16'(a);
    p[2] = 16'(cnt);
    acc = int'(ix != 3'h2 || a % 2 != 0 || cnt == 0 || w + cnt > DP);
    if (acc == 0) begin
      for (int i = 0; i < cnt; i++) if (mem[w + i] != 'hffff) m1 = 1;
    end
    launch(3, ix);
    stat(acc, 0, m1);
  endtask

  initial begin
    for (int i = 0; i < DP; i++) mem[i] = 'hffff;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wait_done();
    rd(FMS_REG_IMASK, rv);
    chk_reg(rv, {14'h0, FMS_IMASK_RST});
    rd(FMS_REG_PROT, rv);
    chk_reg(rv, FMS_PROT_RST);
    wr(4'hf, 16'hffff);
    rd(4'hf, rv);
    chk_reg(rv, 16'h0000);
    @(posedge clk);
    special_mode <= 1'b1;
    repeat (4) @(posedge clk);
    // Field margins only used for a verify pass of fresh contents
    for (int s = 0; s < 6; s++) set_margin(DB, s, 3'h1);
    rd(FMS_REG_INDEX, rv);
    chk_reg(rv, 16'h0001);
    rd(FMS_REG_PARAM, rv);
    chk_reg(rv, 16'h0005);
    set_margin(PB, 3, 3'h1);
    set_margin(7'h22, 1, 3'h1);
    set_margin(DB, 2, 3'h0);
    @(posedge clk);
    special_mode <= 1'b0;
    repeat (4) @(posedge clk);
    set_margin(DB, 4, 3'h1);
    wr(FMS_REG_IMASK, 16'h0001);
    prog(0, 3'h2);
    @(posedge clk);
    #1 chk_pin(10'(irq), 10'h1);
    wr(FMS_REG_ISTAT, 16'h0003);
    @(posedge clk);
    #1 chk_pin(10'(irq), 10'h0);
    wr(FMS_REG_IMASK, 16'h0000);
    prog(2, 3'h5);
    rd(FMS_REG_ISTAT, rv);
    chk_pin({irq, 8'h0, rv[FMS_IRQ_DONE]}, 10'h1);
    prog(10, 3'h3);
    prog(30, 3'h2);
    prog(30, 3'h3);
    prog(13, 3'h2);
    prog(20, 3'h1);
    prog(20, 3'h6);
    rd(FMS_REG_ISTAT, rv);
    chk_reg(rv, 16'h0003);
    prot = 16'h800c;
    wr(FMS_REG_PROT, prot);
    prog(22, 3'h3);
    prog(22, 3'h2);
    prot = 16'h0000;
    wr(FMS_REG_PROT, prot);
    ev(0, 1, 3'h2);
    ev(14, 4, 3'h2);
    ev(24, 4, 3'h2);
    ev(24, 3, 3'h2);
    ev(24, 0, 3'h2);
    ev(26, 4, 3'h2);
    ev(1, 2, 3'h2);
    ev(14, 2, 3'h1);
    give_verdict();
  end
endmodule
